// *** rtl/pwdt_pkg.sv ***
// Package for the prescaled watchdog timer: register map, fields, timing.
// Assumes a 32-bit AXI4-Lite bus and one 20 MHz clock.
package pwdt_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFF_FEED = 4'h0;
   localparam logic [3:0] OFF_PRESCALE = 4'h4;
   localparam logic [3:0] OFF_STATUS = 4'h8;
   localparam logic [3:0] OFF_MASK = 4'hc;
   localparam logic [7:0] FEED_FIRST = 8'h1e;
   localparam logic [7:0] FEED_SECOND = 8'he1;
   localparam logic [2:0] PRESCALE_RST = 3'h0;
   localparam int PRESCALE_W = 3;
   localparam int COUNT_W = 14;
   localparam logic [13:0] COUNT_TOP = 14'h3fff;
   localparam int CLKS_PER_MC = 6;
   localparam int RST_PULSE_CLKS = 98;
   localparam int STAT_TIMEOUT = 0;
   localparam int STAT_ILLEGAL = 1;
   localparam int STAT_ARMED = 2;
   localparam int STAT_W = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {PWDT_IDLE, PWDT_HALF, PWDT_ARMED, PWDT_REFEED} pwdt_state_t;
   typedef struct packed {
      logic timeout;
      logic illegal;
   } pwdt_evt_t;
endpackage

// *** rtl/pwdt_top.sv ***
// Watchdog timer with prescaler and feed-pattern arming, AXI4-Lite registers.
// Assumes a synchronous system reset; sys_reset must not loop back into aresetn.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pwdt_top #(
   parameter int PULSE_CLKS = pwdt_pkg::RST_PULSE_CLKS,
   parameter int MC_CLKS = pwdt_pkg::CLKS_PER_MC
) (
   input wire logic aclk, // Clock, 20 MHz
   input wire logic aresetn, // Synchronous reset, low
   input wire logic [pwdt_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [pwdt_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic sys_reset, // System reset request, high
   output logic ext_reset_pin, // External reset pulse, high
   output logic irq // Level interrupt
);
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [pwdt_pkg::ADDR_W-1:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   pwdt_pkg::pwdt_state_t st_q, st_d;
   logic [pwdt_pkg::PRESCALE_W-1:0] pre_pend_q, pre_pend_d, pre_act_q, pre_act_d;
   logic [13:0] cnt_q, cnt_d;
   logic [10:0] pdiv_q, pdiv_d;
   logic [2:0] mdiv_q, mdiv_d;
   logic [7:0] pulse_q, pulse_d;
   logic srst_q, srst_d, pin_q, pin_d, irq_q, irq_d;
   logic [pwdt_pkg::STAT_W-1:0] stat_q, stat_d, mask_q, mask_d;
   logic do_write, do_read, mc_tick, pre_tick, fire;
   logic wst_q, wst_d, armed, restart;
   logic [10:0] pre_lim;
   pwdt_pkg::pwdt_evt_t evt;
   logic [7:0] wbyte;

   // Prescale factor minus one, per select code
   function automatic logic [10:0] pre_limit(input logic [2:0] sel);
      unique case (sel)
         3'h0: pre_limit = 11'h000;
         3'h1: pre_limit = 11'h003;
         3'h2: pre_limit = 11'h00f;
         3'h3: pre_limit = 11'h03f;
         3'h4: pre_limit = 11'h07f;
         3'h5: pre_limit = 11'h0ff;
         3'h6: pre_limit = 11'h1ff;
         3'h7: pre_limit = 11'h3ff;
      endcase
   endfunction

   assign do_write = aw_q && w_q && !bv_q;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign wbyte = wd_q[7:0];
   assign pre_lim = pre_limit(pre_act_q);
   assign armed = st_q == pwdt_pkg::PWDT_ARMED || st_q == pwdt_pkg::PWDT_REFEED;
   assign mc_tick = armed && (mdiv_q == 3'(MC_CLKS - 1));
   assign pre_tick = mc_tick && (pdiv_q == pre_lim);

   // Bus channels: address and data taken in either order, response after both
   always_comb begin
      aw_d = aw_q;
      awa_d = awa_q;
      w_d = w_q;
      wd_d = wd_q;
      wst_d = wst_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         wst_d = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q == pwdt_pkg::OFF_FEED || awa_q == pwdt_pkg::OFF_PRESCALE ||
                 awa_q == pwdt_pkg::OFF_MASK || awa_q == pwdt_pkg::OFF_STATUS) ?
                pwdt_pkg::RESP_OKAY : pwdt_pkg::RESP_SLVERR;
      end else if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (do_read) begin
         rv_d = 1'b1;
         rr_d = pwdt_pkg::RESP_OKAY;
         rd_d = 32'h0;
         unique case (s_axi_araddr)
            pwdt_pkg::OFF_FEED: rd_d = 32'h0;
            pwdt_pkg::OFF_PRESCALE: rd_d = {29'h0, pre_act_q};
            pwdt_pkg::OFF_STATUS: rd_d = {29'h0, stat_q};
            pwdt_pkg::OFF_MASK: rd_d = {29'h0, mask_q};
            default: rr_d = pwdt_pkg::RESP_SLVERR;
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         awa_q <= '0;
         w_q <= 1'b0;
         wd_q <= 32'h0;
         wst_q <= 1'b0;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h0;
         rr_q <= 2'h0;
      end else begin
         aw_q <= aw_d;
         awa_q <= awa_d;
         w_q <= w_d;
         wd_q <= wd_d;
         wst_q <= wst_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end

   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready = !w_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   // Watchdog core: feed decoder, prescaler, counter, reset pulse
   always_comb begin
      st_d = st_q;
      pre_pend_d = pre_pend_q;
      pre_act_d = pre_act_q;
      cnt_d = cnt_q;
      pdiv_d = pdiv_q;
      mdiv_d = mdiv_q;
      evt = '0;
      restart = 1'b0;
      if (do_write && awa_q == pwdt_pkg::OFF_PRESCALE && wst_q)
         pre_pend_d = wd_q[pwdt_pkg::PRESCALE_W-1:0];
      if (do_write && awa_q == pwdt_pkg::OFF_FEED && wst_q) begin
         if (wbyte == pwdt_pkg::FEED_FIRST) begin
            if (st_q == pwdt_pkg::PWDT_IDLE)
               st_d = pwdt_pkg::PWDT_HALF;
            else if (st_q == pwdt_pkg::PWDT_ARMED)
               st_d = pwdt_pkg::PWDT_REFEED;
         end else if (wbyte == pwdt_pkg::FEED_SECOND) begin
            // A lone second half is harmless; only a completed pair restarts
            if (st_q == pwdt_pkg::PWDT_HALF || st_q == pwdt_pkg::PWDT_REFEED) begin
               st_d = pwdt_pkg::PWDT_ARMED;
               restart = 1'b1;
            end
         end else if (st_q != pwdt_pkg::PWDT_IDLE) begin
            evt.illegal = 1'b1;
         end
         // Any other write while idle changes nothing
      end
      if (restart) begin
         pre_act_d = pre_pend_q;
         cnt_d = pwdt_pkg::COUNT_TOP;
         pdiv_d = 11'h0;
         mdiv_d = 3'h0;
      end else if (armed) begin
         // A half-done feed keeps counting, so a stalled feed still times out
         mdiv_d = mc_tick ? 3'h0 : mdiv_q + 3'h1;
         if (mc_tick)
            pdiv_d = pre_tick ? 11'h0 : pdiv_q + 11'h1;
         if (pre_tick) begin
            if (cnt_q == 14'h0)
               evt.timeout = 1'b1;
            else
               cnt_d = cnt_q - 14'h1;
         end
      end
      // Own reset disarms like any reset; status keeps the cause for software
      if (evt.timeout || evt.illegal) begin
         st_d = pwdt_pkg::PWDT_IDLE;
         pre_pend_d = pwdt_pkg::PRESCALE_RST;
         pre_act_d = pwdt_pkg::PRESCALE_RST;
         cnt_d = pwdt_pkg::COUNT_TOP;
         pdiv_d = 11'h0;
         mdiv_d = 3'h0;
      end
   end

   assign fire = evt.timeout || evt.illegal;

   always_comb begin
      pulse_d = pulse_q;
      srst_d = srst_q;
      pin_d = pin_q;
      if (fire && pulse_q == 8'h0) begin
         pulse_d = 8'(PULSE_CLKS);
         srst_d = 1'b1;
         pin_d = 1'b1;
      end else if (pulse_q != 8'h0) begin
         pulse_d = pulse_q - 8'h1;
         if (pulse_q == 8'h1) begin
            pin_d = 1'b0;
            srst_d = 1'b0;
         end
      end
      // Status sticks; a read clears it but a same-cycle event survives
      stat_d = stat_q;
      if (do_read && s_axi_araddr == pwdt_pkg::OFF_STATUS)
         stat_d = '0;
      if (evt.timeout)
         stat_d[pwdt_pkg::STAT_TIMEOUT] = 1'b1;
      if (evt.illegal)
         stat_d[pwdt_pkg::STAT_ILLEGAL] = 1'b1;
      if (restart && !armed)
         stat_d[pwdt_pkg::STAT_ARMED] = 1'b1;
      mask_d = mask_q;
      if (do_write && awa_q == pwdt_pkg::OFF_MASK && wst_q)
         mask_d = wd_q[pwdt_pkg::STAT_W-1:0];
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= pwdt_pkg::PWDT_IDLE;
         pre_pend_q <= pwdt_pkg::PRESCALE_RST;
         pre_act_q <= pwdt_pkg::PRESCALE_RST;
         cnt_q <= pwdt_pkg::COUNT_TOP;
         pdiv_q <= 11'h0;
         mdiv_q <= 3'h0;
         stat_q <= '0;
         mask_q <= '0;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         pre_pend_q <= pre_pend_d;
         pre_act_q <= pre_act_d;
         cnt_q <= cnt_d;
         pdiv_q <= pdiv_d;
         mdiv_q <= mdiv_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   always_ff @(posedge aclk) begin
      // An outside reset cuts a running pulse; the core disarms itself on firing
      if (!aresetn) begin
         pulse_q <= 8'h0;
         srst_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         pulse_q <= pulse_d;
         srst_q <= srst_d;
         pin_q <= pin_d;
      end
   end

   assign sys_reset = srst_q;
   assign ext_reset_pin = pin_q;
   assign irq = irq_q;

   a_pulse_width: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_q) |=> pin_q [*8]) else $error("Reset pulse too short");
   a_pulse_load: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_q) |-> pulse_q == 8'(PULSE_CLKS) && srst_q) else $error("Bad pulse load");
   a_illegal_fire: assert property (@(posedge aclk) disable iff (!aresetn)
      evt.illegal && pulse_q == 8'h0 |=> pin_q && srst_q) else $error("No reset on bad feed");
   a_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == pwdt_pkg::PWDT_IDLE |-> !fire) else $error("Reset while idle");
   a_stay_armed: assert property (@(posedge aclk) disable iff (!aresetn)
      armed && !fire |=> armed) else $error("Disarmed");
   a_self_disarm: assert property (@(posedge aclk) disable iff (!aresetn)
      fire |=> st_q == pwdt_pkg::PWDT_IDLE) else $error("Armed after own reset");
   a_reset_idle: assert property (@(posedge aclk)
      !aresetn |=> st_q == pwdt_pkg::PWDT_IDLE) else $error("Not idle after reset");
   a_arm_reload: assert property (@(posedge aclk) disable iff (!aresetn)
      restart |=> st_q == pwdt_pkg::PWDT_ARMED && cnt_q == pwdt_pkg::COUNT_TOP
      && pre_act_q == $past(pre_pend_q)) else $error("No reload");
   a_idle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !armed |=> $stable(pdiv_q)) else $error("Prescaler ran");
   a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
      pre_tick && cnt_q != 14'h0 && !restart && !evt.illegal
      |=> cnt_q == $past(cnt_q) - 14'h1) else $error("Bad count step");
   c_armed: cover property (@(posedge aclk) st_q == pwdt_pkg::PWDT_ARMED);
   c_refeed: cover property (@(posedge aclk) st_q == pwdt_pkg::PWDT_REFEED);
   c_timeout: cover property (@(posedge aclk) evt.timeout);
   c_illegal: cover property (@(posedge aclk) evt.illegal);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the prescaled watchdog timer.
// Assumes pwdt_top with an AXI4-Lite slave; read results are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int PULSE = pwdt_pkg::RST_PULSE_CLKS;
   localparam int MC = 2;
   localparam int SPAN = 16383 * MC;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sys_reset, ext_reset_pin, irq, sr;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [33:0] exp_q[$];
   logic [31:0] care_q[$];
   int bad_count = 0;
   int checked = 0;
   int cyc = 0, rise = 0, hi = 0, width = 0, t0;
   logic [7:0] v;
   always #25 aclk = ~aclk;
   pwdt_top #(.MC_CLKS(MC)) u_pwdt_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sys_reset(sys_reset), .ext_reset_pin(ext_reset_pin), .irq(irq));
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Pulse watcher samples mid-cycle so it never races the design's edge
   always @(negedge aclk) begin
      cyc++;
      if (ext_reset_pin === 1'b1) begin
         if (hi == 0) begin
            rise = cyc;
            sr = sys_reset;
         end
         hi++;
      end else if (hi != 0) begin
         width = hi;
         hi = 0;
      end
   end
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
         chk({rresp, rdata & care_q.pop_front()}, exp_q.pop_front());
      end
   end
   task automatic rst();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bit pa, pw, ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge aclk);
         pa = awvalid && awready === 1'b1;
         pw = wvalid && wready === 1'b1;
         @(posedge aclk);
         if (pa) begin
            ta = 1'b1;
            awvalid <= 1'b0;
         end
         if (pw) begin
            tw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(negedge aclk); while (bvalid !== 1'b1);
      chk({32'h0, bresp}, {32'h0, pwdt_pkg::RESP_OKAY});
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] c,
         input logic [1:0] r = pwdt_pkg::RESP_OKAY);
      exp_q.push_back({r, e & c});
      care_q.push_back(c);
      araddr <= a;
      arvalid <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(negedge aclk); while (rvalid !== 1'b1);
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic feed();
      wr(pwdt_pkg::OFF_FEED, pwdt_pkg::FEED_FIRST);
      wr(pwdt_pkg::OFF_FEED, pwdt_pkg::FEED_SECOND);
   endtask
   task automatic wt(input int lim);
      int t;
      t = cyc;
      while (width == 0 && cyc - t < lim) @(posedge aclk);
   endtask
   initial begin
      repeat (60000) @(posedge aclk);
      bad_count++;
      wrap_up();
   end
   initial begin
      void'($urandom(58));
      rst();
      rd(pwdt_pkg::OFF_FEED, 32'h0, 32'hff);
      rd(pwdt_pkg::OFF_STATUS, 32'h0, 32'h7);
      rd(4'h6, 32'h0, 32'h0, pwdt_pkg::RESP_SLVERR);
      for (int c = 0; c < 8; c++) begin
         rst();
         wr(pwdt_pkg::OFF_PRESCALE, 8'(c));
         rd(pwdt_pkg::OFF_PRESCALE, 32'h0, 32'h7);
         feed();
         rd(pwdt_pkg::OFF_PRESCALE, 32'(c), 32'h7);
      end
      rst();
      do v = 8'($urandom); while (v == pwdt_pkg::FEED_FIRST);
      width = 0;
      rise = 0;
      wr(pwdt_pkg::OFF_FEED, v);
      wt(30);
      chk(34'(rise), 34'h0);
      rd(pwdt_pkg::OFF_STATUS, 32'h0, 32'h7);
      wr(pwdt_pkg::OFF_MASK, 8'h02);
      wr(pwdt_pkg::OFF_FEED, pwdt_pkg::FEED_FIRST);
      do v = 8'($urandom); while (v == pwdt_pkg::FEED_FIRST || v == pwdt_pkg::FEED_SECOND);
      t0 = cyc;
      wr(pwdt_pkg::OFF_FEED, v);
      wt(PULSE + 50);
      chk(34'(rise > t0 && rise - t0 <= 8), 34'h1);
      chk({32'(width), sr, irq}, {32'(PULSE), 2'h3});
      rd(pwdt_pkg::OFF_STATUS, 32'h2, 32'h2);
      rst();
      wr(pwdt_pkg::OFF_MASK, 8'h02);
      feed();
      rise = 0;
      wr(pwdt_pkg::OFF_FEED, pwdt_pkg::FEED_SECOND);
      repeat (10) @(posedge aclk);
      chk(34'(rise), 34'h0);
      rd(pwdt_pkg::OFF_STATUS, 32'h4, 32'h4);
      repeat (5000 + $urandom % 5000) @(posedge aclk);
      width = 0;
      feed();
      t0 = cyc;
      wt(SPAN + PULSE + 100);
      chk(34'(rise - t0 >= SPAN - 6 && rise - t0 <= SPAN + 6), 34'h1);
      chk({32'(width), sr, irq}, {32'(PULSE), 2'h2});
      wr(pwdt_pkg::OFF_MASK, 8'h01);
      repeat (2) @(posedge aclk);
      chk({33'h0, irq}, 34'h1);
      rd(pwdt_pkg::OFF_STATUS, 32'h1, 32'h3);
      rd(pwdt_pkg::OFF_STATUS, 32'h0, 32'h3);
      repeat (2) @(posedge aclk);
      chk({33'h0, irq}, 34'h0);
      rst();
      rd(pwdt_pkg::OFF_STATUS, 32'h0, 32'h7);
      wrap_up();
   end
endmodule
`default_nettype wire
